//--- hdl/qdc_pkg.sv
package qdc_pkg;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS    = 24;
  localparam int RW_BIT        = 23;
  localparam int CHIP_ADDR_MSB = 22;
  localparam int CHIP_ADDR_LSB = 21;
  localparam int DATA_REG_SELECT_MSB      = 20;
  localparam int DATA_REG_SELECT_LSB      = 18;
  localparam int CHAN_MSB      = 17;
  localparam int CHAN_LSB      = 16;
  localparam int CTRL_SUB_ADDRESS_MSB      = 15;
  localparam int CTRL_SUB_ADDRESS_LSB      = 13;
  localparam int NUM_CHANNELS  = 4;

  // ------------------------------------------------------------
  // Data register select codes
  // ------------------------------------------------------------
  localparam logic [2:0] DATA_REG_SELECT_OFFSET     = 3'h4;
  localparam logic [2:0] DATA_REG_SELECT_OFFSET_ALL = 3'h5;
  localparam logic [2:0] DATA_REG_SELECT_CLEAR      = 3'h6;
  localparam logic [2:0] DATA_REG_SELECT_CONTROL    = 3'h7;

  // ------------------------------------------------------------
  // Control sub-address codes
  // ------------------------------------------------------------
  localparam logic [2:0] CTRL_SUB_ADDRESS_SLEW     = 3'h0;
  localparam logic [2:0] CTRL_SUB_ADDRESS_MAIN     = 3'h1;
  localparam logic [2:0] CTRL_SUB_ADDRESS_CHANNEL  = 3'h2;
  localparam logic [2:0] CTRL_SUB_ADDRESS_CONVERT  = 3'h3;
  localparam logic [2:0] CTRL_SUB_ADDRESS_SOFTWARE = 3'h4;

  // ------------------------------------------------------------
  // Global control field positions
  // ------------------------------------------------------------
  localparam int GC_STATUS_READBACK = 11;
  localparam int GC_WATCHDOG_EN     = 10;
  localparam int GC_TIMEOUT_HI      = 9;
  localparam int GC_TIMEOUT_LO      = 8;
  localparam int GC_ALL_OUTPUTS     = 5;
  localparam int GC_ALL_CONVERTERS  = 4;

  // ------------------------------------------------------------
  // Channel control field positions
  // ------------------------------------------------------------
  localparam int CC_INT_ENABLE  = 8;
  localparam int CC_CLEAR_ALLOW = 7;
  localparam int CC_OUTPUT_ON   = 6;
  localparam int CC_SENSE_RES   = 5;
  localparam int CC_CONVERTER   = 4;
  localparam int CC_RANGE_MSB   = 2;
  localparam int CC_RANGE_LSB   = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] OFFSET_RESET      = 16'h8000;
  localparam logic [15:0] CLEAR_RESET       = 16'h0000;
  localparam logic [15:0] GLOBAL_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CHAN_CTRL_RESET   = 16'h0000;

  // ------------------------------------------------------------
  // Watchdog timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_KHZ  = 50_000;
  localparam int WD_TIME0_MS   = 5;
  localparam int WD_TIME1_MS   = 10;
  localparam int WD_TIME2_MS   = 100;
  localparam int WD_TIME3_MS   = 200;
  localparam int WD_CYCLES0    = WD_TIME0_MS * CLK_FREQ_KHZ;
  localparam int WD_CYCLES1    = WD_TIME1_MS * CLK_FREQ_KHZ;
  localparam int WD_CYCLES2    = WD_TIME2_MS * CLK_FREQ_KHZ;
  localparam int WD_CYCLES3    = WD_TIME3_MS * CLK_FREQ_KHZ;

endpackage : qdc_pkg

//--- hdl/qdc_reg_decode.sv
`timescale 1ns/1ns
module qdc_reg_decode #(
  parameter int NCH     = qdc_pkg::NUM_CHANNELS,
  parameter int WD_CYC0 = qdc_pkg::WD_CYCLES0,
  parameter int WD_CYC1 = qdc_pkg::WD_CYCLES1,
  parameter int WD_CYC2 = qdc_pkg::WD_CYCLES2,
  parameter int WD_CYC3 = qdc_pkg::WD_CYCLES3
) (
  // System
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Strapped device address
  input  wire logic              chip_addr_hi,
  input  wire logic              chip_addr_lo,
  // Serial link
  input  wire logic              link_sclk,
  input  wire logic              link_sync_n,
  input  wire logic              link_sdin,
  output logic                   link_sdo,
  // Channel registers
  output logic [NCH*16-1:0]      channel_offset_trim,
  output logic [NCH*16-1:0]      channel_clear_value,
  output logic [NCH*16-1:0]      channel_control,
  // Global control register and fields
  output logic [15:0]            global_control,
  output logic                   status_readback_en,
  output logic                   watchdog_en,
  output logic                   timeout_sel_hi,
  output logic                   timeout_sel_lo,
  output logic                   all_outputs_on,
  output logic                   all_converters_on,
  // Effective per-channel controls
  output logic [NCH-1:0]         channel_output_on,
  output logic [NCH-1:0]         channel_converter_on,
  // Watchdog
  output logic                   watchdog_fault
);

  // ------------------------------------------------------------
  // Link domain: frame capture
  // ------------------------------------------------------------
  logic        frame_rst;
  logic [4:0]  bit_count;
  logic [23:0] shift_in;
  logic [23:0] frame_word;
  logic        frame_toggle;
  logic [23:0] next_shift;

  assign frame_rst  = link_sync_n | ~resetn;
  assign next_shift = {shift_in[22:0], link_sdin};

  always_ff @(posedge link_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_count <= 5'h00;
    end else if (bit_count != 5'(qdc_pkg::FRAME_BITS)) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  always_ff @(posedge link_sclk or negedge resetn) begin
    if (!resetn) begin
      shift_in     <= 24'h00_0000;
      frame_word   <= 24'h00_0000;
      frame_toggle <= 1'b0;
    end else if (!link_sync_n
                 && bit_count != 5'(qdc_pkg::FRAME_BITS)) begin
      shift_in <= next_shift;
      if (bit_count == 5'(qdc_pkg::FRAME_BITS - 1)) begin
        frame_word   <= next_shift;
        frame_toggle <= ~frame_toggle;
      end
    end
  end

  // ------------------------------------------------------------
  // Link domain: status return
  // ------------------------------------------------------------
  logic [NCH+1:0] stat_meta;
  logic [NCH+1:0] stat_sync;
  logic [23:0]    stat_frame;

  always_ff @(posedge link_sclk or negedge resetn) begin
    if (!resetn) begin
      stat_meta <= '0;
      stat_sync <= '0;
    end else begin
      stat_meta <= {status_readback_en, watchdog_fault,
                    channel_output_on};
      stat_sync <= stat_meta;
    end
  end

  assign stat_frame = {8'h00, 16'(stat_sync[NCH:0])};

  always_ff @(posedge link_sclk or negedge resetn) begin
    if (!resetn) begin
      link_sdo <= 1'b0;
    end else if (stat_sync[NCH+1] && !link_sync_n
                 && bit_count != 5'(qdc_pkg::FRAME_BITS)) begin
      link_sdo <= stat_frame[5'(qdc_pkg::FRAME_BITS - 1) - bit_count];
    end else begin
      link_sdo <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Crossing into the register domain
  // ------------------------------------------------------------
  logic [2:0] tog_sync;
  logic [1:0] addr_meta;
  logic [1:0] addr_sync;
  logic       frame_done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tog_sync  <= 3'h0;
      addr_meta <= 2'h0;
      addr_sync <= 2'h0;
    end else begin
      tog_sync  <= {tog_sync[1:0], frame_toggle};
      addr_meta <= {chip_addr_hi, chip_addr_lo};
      addr_sync <= addr_meta;
    end
  end

  assign frame_done = tog_sync[2] ^ tog_sync[1];

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic       wr_ok;
  logic [2:0] data_reg_select;
  logic [2:0] ctrl_sub_address;
  logic [1:0] chan;
  logic [15:0] payload;

  assign data_reg_select    = frame_word[qdc_pkg::DATA_REG_SELECT_MSB:qdc_pkg::DATA_REG_SELECT_LSB];
  assign chan    = frame_word[qdc_pkg::CHAN_MSB:qdc_pkg::CHAN_LSB];
  assign ctrl_sub_address    = frame_word[qdc_pkg::CTRL_SUB_ADDRESS_MSB:qdc_pkg::CTRL_SUB_ADDRESS_LSB];
  assign payload = frame_word[15:0];
  assign wr_ok   = frame_done && !frame_word[qdc_pkg::RW_BIT]
                   && frame_word[qdc_pkg::CHIP_ADDR_MSB:
                                 qdc_pkg::CHIP_ADDR_LSB] == addr_sync;

  // ------------------------------------------------------------
  // Global control register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      global_control <= qdc_pkg::GLOBAL_CTRL_RESET;
    end else if (wr_ok && data_reg_select == qdc_pkg::DATA_REG_SELECT_CONTROL
                 && ctrl_sub_address == qdc_pkg::CTRL_SUB_ADDRESS_MAIN) begin
      global_control <= {4'h0,
                         payload[qdc_pkg::GC_STATUS_READBACK:
                                 qdc_pkg::GC_TIMEOUT_LO],
                         2'b00,
                         payload[qdc_pkg::GC_ALL_OUTPUTS:
                                 qdc_pkg::GC_ALL_CONVERTERS],
                         4'h0};
    end
  end

  assign status_readback_en = global_control[qdc_pkg::GC_STATUS_READBACK];
  assign watchdog_en        = global_control[qdc_pkg::GC_WATCHDOG_EN];
  assign timeout_sel_hi     = global_control[qdc_pkg::GC_TIMEOUT_HI];
  assign timeout_sel_lo     = global_control[qdc_pkg::GC_TIMEOUT_LO];
  assign all_outputs_on     = global_control[qdc_pkg::GC_ALL_OUTPUTS];
  assign all_converters_on  = global_control[qdc_pkg::GC_ALL_CONVERTERS];

  // ------------------------------------------------------------
  // Per-channel registers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic hit;
      assign hit = wr_ok && chan == 2'(g);

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          channel_offset_trim[g*16 +: 16] <= qdc_pkg::OFFSET_RESET;
        end else if ((hit && data_reg_select == qdc_pkg::DATA_REG_SELECT_OFFSET)
                     || (wr_ok
                         && data_reg_select == qdc_pkg::DATA_REG_SELECT_OFFSET_ALL)) begin
          channel_offset_trim[g*16 +: 16] <= payload;
        end
      end

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          channel_clear_value[g*16 +: 16] <= qdc_pkg::CLEAR_RESET;
        end else if (hit && data_reg_select == qdc_pkg::DATA_REG_SELECT_CLEAR) begin
          channel_clear_value[g*16 +: 16] <= payload;
        end
      end

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          channel_control[g*16 +: 16] <= qdc_pkg::CHAN_CTRL_RESET;
        end else if (hit && data_reg_select == qdc_pkg::DATA_REG_SELECT_CONTROL
                     && ctrl_sub_address == qdc_pkg::CTRL_SUB_ADDRESS_CHANNEL) begin
          channel_control[g*16 +: 16] <= {7'h00,
            payload[qdc_pkg::CC_INT_ENABLE:qdc_pkg::CC_CONVERTER],
            1'b0,
            payload[qdc_pkg::CC_RANGE_MSB:qdc_pkg::CC_RANGE_LSB]};
        end
      end

      assign channel_output_on[g] = all_outputs_on
        || channel_control[g*16 + qdc_pkg::CC_OUTPUT_ON];
      assign channel_converter_on[g] = all_converters_on
        || channel_control[g*16 + qdc_pkg::CC_CONVERTER];
    end
  endgenerate

  // Slew, converter, software and codes 101..111 store nothing

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  logic [31:0] wd_count;
  logic [31:0] wd_limit;

  always_comb begin
    case ({timeout_sel_hi, timeout_sel_lo})
      2'b00:   wd_limit = 32'(WD_CYC0);
      2'b01:   wd_limit = 32'(WD_CYC1);
      2'b10:   wd_limit = 32'(WD_CYC2);
      default: wd_limit = 32'(WD_CYC3);
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wd_count <= 32'h0000_0000;
    end else if (!watchdog_en || wr_ok) begin
      wd_count <= 32'h0000_0000;
    end else if (wd_count != wd_limit) begin
      wd_count <= wd_count + 32'h0000_0001;
    end
  end

  // Timeout wins over a write in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_fault <= 1'b0;
    end else if (!watchdog_en) begin
      watchdog_fault <= 1'b0;
    end else if (wd_count == wd_limit - 32'h0000_0001) begin
      watchdog_fault <= 1'b1;
    end else if (wr_ok) begin
      watchdog_fault <= 1'b0;
    end
  end

  // Host sequencing of power-down is not enforced here

endmodule : qdc_reg_decode

//--- sim/qdc_host_model.sv
`timescale 1ns/1ns
// ----------------
// Serial host
// ----------------
module qdc_host_model (
  // Serial link
  output logic      link_sclk,
  output logic      link_sync_n,
  output logic      link_sdin,
  input  wire logic link_sdo
);
  logic [23:0] rx;
  initial begin
    rx          = 24'h00_0000;
    link_sclk   = 1'b0;
    link_sync_n = 1'b1;
    link_sdin   = 1'b0;
  end
  // Clock stands still between frames; caller orders frames
  task automatic send(input logic [23:0] w);
    #7 link_sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      link_sdin = w[i];
      #40 link_sclk = 1'b1;
      #40 link_sclk = 1'b0;
      rx = {rx[22:0], link_sdo};
    end
    #40 link_sync_n = 1'b1;
    link_sdin = ~link_sdin;
  endtask : send
endmodule : qdc_host_model

//--- sim/qdc_reg_decode_assertions.sv
`timescale 1ns/1ns
module qdc_reg_decode_assertions #(
  parameter int NCH = 4,
  parameter int WD_CYC0 = 20,
  parameter int WD_CYC1 = 40,
  parameter int WD_CYC2 = 80,
  parameter int WD_CYC3 = 160
) (
  // System and link
  input wire logic             ref_clk,
  input wire logic             resetn,
  input wire logic             link_sync_n,
  // Registers
  input wire logic [NCH*16-1:0] channel_offset_trim,
  input wire logic [NCH*16-1:0] channel_clear_value,
  input wire logic [NCH*16-1:0] channel_control,
  input wire logic [15:0]       global_control,
  // Fields
  input wire logic             status_readback_en,
  input wire logic             watchdog_en,
  input wire logic             timeout_sel_hi,
  input wire logic             timeout_sel_lo,
  input wire logic             all_outputs_on,
  input wire logic             all_converters_on,
  input wire logic [NCH-1:0]   channel_output_on,
  input wire logic [NCH-1:0]   channel_converter_on,
  input wire logic             watchdog_fault
);
  logic [3:0]     fcnt;
  int             idle;
  int             lim;
  logic [NCH-1:0] oexp;
  logic [NCH-1:0] cexp;
  logic           cc_bad;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fcnt <= 4'h0;
      idle <= 0;
    end else if (!link_sync_n) begin
      fcnt <= 4'h0;
      idle <= 0;
    end else begin
      idle <= idle + 1;
      if (fcnt != 4'hf) fcnt <= fcnt + 4'h1;
    end
  end
  always_comb begin
    cc_bad = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      oexp[i] = all_outputs_on | channel_control[16*i+6];
      cexp[i] = all_converters_on | channel_control[16*i+4];
      cc_bad = cc_bad | (|channel_control[16*i+9 +: 7])
             | channel_control[16*i+3];
    end
    case ({timeout_sel_hi, timeout_sel_lo})
      2'b00: lim = WD_CYC0;
      2'b01: lim = WD_CYC1;
      2'b10: lim = WD_CYC2;
      default: lim = WD_CYC3;
    endcase
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_out_en; channel_output_on == oexp; endproperty
  a_out_en: assert property (p_out_en)
    else $error("output enables wrong");
  property p_cnv_en; channel_converter_on == cexp; endproperty
  a_cnv_en: assert property (p_cnv_en)
    else $error("converter enables wrong");
  property p_gc_fields;
    {status_readback_en, watchdog_en, timeout_sel_hi, timeout_sel_lo,
     all_outputs_on, all_converters_on}
      == {global_control[11:8], global_control[5:4]};
  endproperty
  a_gc_fields: assert property (p_gc_fields)
    else $error("global fields wrong");
  property p_gc_junk;
    (global_control & 16'hf0cf) == 16'h0000;
  endproperty
  a_gc_junk: assert property (p_gc_junk)
    else $error("ignored global bits set");
  property p_cc_junk; !cc_bad; endproperty
  a_cc_junk: assert property (p_cc_junk)
    else $error("ignored channel bits set");
  property p_frame_only;
    $changed({channel_offset_trim, channel_clear_value, channel_control,
              global_control}) |-> fcnt < 4'h8;
  endproperty
  a_frame_only: assert property (p_frame_only)
    else $error("register changed with no frame");
  property p_wd_off; !watchdog_en [*3] |-> !watchdog_fault; endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("fault while watchdog off");
  property p_wd_late; $rose(watchdog_fault) |-> idle <= lim + 12; endproperty
  a_wd_late: assert property (p_wd_late)
    else $error("watchdog fault late");
  c_wd: cover property ($rose(watchdog_fault));
  c_all: cover property ($rose(all_outputs_on));
  c_frame: cover property ($rose(link_sync_n));
endmodule : qdc_reg_decode_assertions
bind qdc_reg_decode qdc_reg_decode_assertions #(.NCH(NCH),
  .WD_CYC0(WD_CYC0), .WD_CYC1(WD_CYC1), .WD_CYC2(WD_CYC2),
  .WD_CYC3(WD_CYC3)) u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .link_sync_n(link_sync_n), .channel_offset_trim(channel_offset_trim),
  .channel_clear_value(channel_clear_value),
  .channel_control(channel_control), .global_control(global_control),
  .status_readback_en(status_readback_en), .watchdog_en(watchdog_en),
  .timeout_sel_hi(timeout_sel_hi), .timeout_sel_lo(timeout_sel_lo),
  .all_outputs_on(all_outputs_on), .all_converters_on(all_converters_on),
  .channel_output_on(channel_output_on),
  .channel_converter_on(channel_converter_on),
  .watchdog_fault(watchdog_fault));

//--- sim/qdc_reg_decode_tb_top.sv
`timescale 1ns/1ns
module qdc_reg_decode_tb_top;
  localparam logic [1:0]  ADR = 2'h2;
  localparam int          WD [4] = '{20, 40, 80, 160};
  localparam logic [15:0] GCW [3] = '{16'h3fff, 16'h2010, 16'h2000};
  localparam logic [15:0] GCE [3] = '{16'h0f30, 16'h0010, 16'h0000};
  localparam logic [23:0] BAD [9] = '{24'hd8_ffff, 24'h38_ffff,
    24'h40_ffff, 24'h5c_1fff, 24'h5c_7fff, 24'h5c_9fff, 24'h5c_bfff,
    24'h5c_dfff, 24'h5c_ffff};
  logic        ref_clk;
  logic        resetn;
  logic        chip_addr_hi;
  logic        chip_addr_lo;
  logic        link_sclk;
  logic        link_sync_n;
  logic        link_sdin;
  logic        link_sdo;
  logic [63:0] off;
  logic [63:0] clr;
  logic [63:0] cc;
  logic [15:0] gc;
  logic [3:0]  out_on;
  logic        wd_fault;
  logic [207:0] snap;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n;
  always #10 ref_clk = ~ref_clk;
  qdc_host_model u_host (.link_sclk(link_sclk), .link_sync_n(link_sync_n),
    .link_sdin(link_sdin), .link_sdo(link_sdo));
  qdc_reg_decode #(.WD_CYC0(WD[0]), .WD_CYC1(WD[1]), .WD_CYC2(WD[2]),
    .WD_CYC3(WD[3])) dut (.ref_clk(ref_clk), .resetn(resetn),
    .chip_addr_hi(chip_addr_hi), .chip_addr_lo(chip_addr_lo),
    .link_sclk(link_sclk), .link_sync_n(link_sync_n),
    .link_sdin(link_sdin), .link_sdo(link_sdo),
    .channel_offset_trim(off), .channel_clear_value(clr),
    .channel_control(cc), .global_control(gc), .status_readback_en(),
    .watchdog_en(), .timeout_sel_hi(), .timeout_sel_lo(),
    .all_outputs_on(), .all_converters_on(), .channel_output_on(out_on),
    .channel_converter_on(), .watchdog_fault(wd_fault));
  function automatic logic [23:0] fw(input logic [2:0] s,
                                     input logic [1:0] c,
                                     input logic [15:0] d);
    return {1'b0, ADR, s, c, d};
  endfunction : fw
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [23:0] w);
    @(negedge ref_clk);
    u_host.send(w);
    repeat (8) @(negedge ref_clk);
  endtask : wr
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    chip_addr_hi = ADR[1];
    chip_addr_lo = ADR[0];
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("offset", off, {4{16'h8000}});
    chk("clear", clr, 64'h0);
    chk("global", {48'h0, gc}, 64'h0);
    $display("test reset done");
    wr(fw(3'h4, 2'h2, 16'hffff));
    wr(fw(3'h5, 2'h3, 16'h1234));
    wr(fw(3'h4, 2'h1, 16'h0000));
    chk("offset", off, 64'h1234_1234_0000_1234);
    wr(fw(3'h6, 2'h1, 16'habcd));
    chk("clear", clr, 64'h0000_0000_abcd_0000);
    // Per-channel output and converter bits left clear
    wr(fw(3'h7, 2'h3, 16'h5faf));
    chk("chan_ctrl", cc, 64'h01a7_0000_0000_0000);
    $display("test data registers done");
    for (int i = 0; i < 3; i++) begin
      wr(fw(3'h7, 2'h0, GCW[i]));
      chk("global", {48'h0, gc}, {48'h0, GCE[i]});
      chk("status", {40'h0, u_host.rx}, (i == 1) ? 64'hf : 64'h0);
      chk("out_on", {60'h0, out_on}, (i == 0) ? 64'hf : 64'h0);
    end
    $display("test main control done");
    snap = {off, clr, cc, gc};
    for (int i = 0; i < 9; i++) begin
      wr(BAD[i]);
      chk("refused", {63'h0, snap === {off, clr, cc, gc}}, 64'h1);
    end
    $display("test refused frames done");
    for (int c = 0; c < 4; c++) begin
      wr(fw(3'h7, 2'h0, 16'h2400 | {6'h0, c[1:0], 8'h00}));
      for (n = 0; n < 400 && wd_fault !== 1'b1; n++) @(negedge ref_clk);
      if (n == 400) begin
        n_mismatch++;
        wrap_up();
      end
      chk("wd_time", {63'h0, n >= WD[c] - 11 && n <= WD[c] - 4}, 64'h1);
    end
    wr(fw(3'h7, 2'h0, 16'h2000));
    chk("wd_fault", {63'h0, wd_fault}, 64'h0);
    $display("test watchdog done");
    wrap_up();
  end
endmodule : qdc_reg_decode_tb_top
